// ### logic/pof_fifo.sv
// Pixel word FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module pof_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 16
) (
    // Clock, reset, enable
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power of two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("pof_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];    // Storage array
    logic [AW-1:0]    wptr_ff;        // Write pointer
    logic [AW-1:0]    rptr_ff;        // Read pointer
    logic [AW:0]      cnt_ff;         // Words held in the array
    logic [AW:0]      nxt_cnt;        // Count after this cycle
    logic             wr;             // Accepted write
    logic             ld;             // Move head into output register

    assign wr = ce_i && in_valid_i && in_ready_o;
    // Refill the output stage when it is empty or being drained
    assign ld = ce_i && (cnt_ff != '0) && (!out_valid_o || out_ready_i);
    assign nxt_cnt = cnt_ff + (AW+1)'(wr) - (AW+1)'(ld);

    // Array write, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (wr) begin
            mem[wptr_ff] <= in_data_i;
        end
    end

    // Pointers, count and full flag
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wptr_ff    <= '0;
            rptr_ff    <= '0;
            cnt_ff     <= '0;
            in_ready_o <= 1'b0;
        end else if (ce_i) begin
            if (wr) begin
                wptr_ff <= wptr_ff + AW'(1);
            end
            if (ld) begin
                rptr_ff <= rptr_ff + AW'(1);
            end
            cnt_ff     <= nxt_cnt;
            // Ready is a flop so back-pressure is glitch free
            in_ready_o <= (nxt_cnt != (AW+1)'(DEPTH));
        end
    end

    // Registered head word
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (ld) begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem[rptr_ff];
        end else if (ce_i && out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### logic/pof_formatter.sv
// Parallel output formatter: packs pixels onto the 8/10-bit output port
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pof_formatter #(
    parameter int PCLK_HALF  = pof_pkg::PCLK_HALF_CYC,
    parameter int FIFO_DEPTH = pof_pkg::FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    // Pixel stream in
    input  wire logic        pix_valid_i,
    output logic             pix_ready_o,
    input  wire logic        pix_sof_i,
    input  wire logic        pix_eol_i,
    input  wire logic        pix_eof_i,
    input  wire logic [23:0] pix_data_i,
    // Parallel output port
    output logic             pixel_output_clock_o,
    output logic             field_active_flag_o,
    output logic             row_active_flag_o,
    output logic [7:0]       parallel_out_bus_o,
    output logic [1:0]       aux_lsb_pins_o
);
    localparam int DW = $clog2(PCLK_HALF + 1);

    // Divider needs at least one cycle per half period
    if (PCLK_HALF < 1) begin : g_bad_half
        $error("pof_formatter PCLK_HALF must be at least 1");
    end

    // Byte emitter states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CODE_S,
        ST_FIRST,
        ST_SECOND,
        ST_CODE_E
    } pof_state_t;

    pof_state_t st_ff;                       // Emitter state
    logic [DW-1:0]  div_ff;                  // Pixel clock divider
    logic [4:0]     ctrl_ff;                 // Software mode and swaps
    logic [4:0]     cfg_ff;                  // Mode in force this frame
    logic [4:0]     nxt_cfg;                 // Mode for a line being opened
    logic [26:0]    pix_ff;                  // Pixel being emitted
    logic           have_ff;                 // Pixel register full
    logic           odd_ff;                  // Odd pixel within the line
    logic [7:0]     hold_ff;                 // Second chroma of a group
    logic [1:0]     cidx_ff;                 // Reference code byte index
    logic           eofp_ff;                 // Frame ended, drop field flag
    logic [15:0]    frm_ff;                  // Frames started
    logic           f_valid;                 // FIFO head present
    logic           f_full;                  // FIFO cannot take more
    logic [26:0]    f_data;                  // FIFO head word
    logic           pop;                     // Take head into pix_ff
    logic           tick;                    // Falling pixel clock edge
    logic           emit0;                   // First byte of a pixel out
    logic           emit1;                   // Second byte of a pixel out
    logic           one_byte;                // Pixel fits one port word
    logic           is656;                   // Embedded code mode active
    logic           ld_cfg;                  // Frame start takes new mode

    // Byte of a pixel for the current packing
    function automatic logic [7:0] byte_sel(input logic [4:0]  cfg,
                                            input logic [23:0] px,
                                            input logic        odd,
                                            input logic [7:0]  hold,
                                            input logic        idx);
        logic [7:0] chroma;
        logic [7:0] res;
        // Even pixel leads with Cb unless swapped, odd uses the held one
        chroma = odd ? hold :
                 (cfg[pof_pkg::CTRL_CSWAP] ? px[7:0] : px[15:8]);
        case (cfg[2:0])
            pof_pkg::MODE_YCBCR, pof_pkg::MODE_BT656: begin
                // Luma first when the luma-chroma swap is set
                res = (cfg[pof_pkg::CTRL_YCSWAP] ^ idx) ? px[23:16]
                                                         : chroma;
            end
            pof_pkg::MODE_RGB16: begin
                res = idx ? {px[12:10], px[7:3]}
                          : {px[23:19], px[15:13]};
            end
            pof_pkg::MODE_RGB15: begin
                res = idx ? {px[13:11], px[7:3]}
                          : {1'b0, px[23:19], px[15:14]};
            end
            pof_pkg::MODE_RGB12L: begin
                res = idx ? {px[7:4], 4'h0}
                          : {px[23:20], px[15:12]};
            end
            pof_pkg::MODE_RGB12H: begin
                res = idx ? {px[15:12], px[7:4]}
                          : {4'h0, px[23:20]};
            end
            pof_pkg::MODE_RAWAUX: begin
                res = px[9:2];
            end
            pof_pkg::MODE_RAW2B: begin
                // Raw sample used as-is, no pipeline touches it
                res = idx ? {6'h00, px[1:0]} : px[9:2];
            end
            default: begin
                res = 8'h00;
            end
        endcase
        return res;
    endfunction

    // Timing reference byte by index
    function automatic logic [7:0] code_sel(input logic [1:0] idx,
                                            input logic [7:0] xy);
        logic [7:0] res;
        res = (idx == 2'h0) ? pof_pkg::CODE_PRE0 :
              (idx == 2'h3) ? xy : pof_pkg::CODE_PRE1;
        return res;
    endfunction

    // Input buffer; its ready is the stream's back-pressure
    pof_fifo #(
        .WIDTH (pof_pkg::WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .ce_i        (ce_i),
        .in_valid_i  (pix_valid_i),
        .in_ready_o  (pix_ready_o),
        .in_data_i   ({pix_sof_i, pix_eol_i, pix_eof_i, pix_data_i}),
        .out_valid_o (f_valid),
        .out_ready_i (pop),
        .out_data_o  (f_data)
    );

    assign f_full   = !pix_ready_o;
    assign pop      = ce_i && f_valid && !have_ff;
    assign tick     = ce_i && pixel_output_clock_o &&
                      (div_ff == DW'(PCLK_HALF - 1));
    assign is656    = (cfg_ff[2:0] == pof_pkg::MODE_BT656);
    assign one_byte = (cfg_ff[2:0] == pof_pkg::MODE_RAWAUX);
    assign emit0    = tick && (st_ff == ST_FIRST) && have_ff;
    assign emit1    = tick && (st_ff == ST_SECOND);
    assign ld_cfg   = tick && (st_ff == ST_IDLE) && have_ff &&
                      pix_ff[pof_pkg::F_SOF];
    // A frame start picks up software's latest choice
    assign nxt_cfg  = pix_ff[pof_pkg::F_SOF] ? ctrl_ff : cfg_ff;

    // Pixel clock divider; data changes on the falling edge
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            div_ff               <= '0;
            pixel_output_clock_o <= 1'b0;
        end else if (ce_i) begin
            if (div_ff == DW'(PCLK_HALF - 1)) begin
                div_ff               <= '0;
                pixel_output_clock_o <= !pixel_output_clock_o;
            end else begin
                div_ff <= div_ff + DW'(1);
            end
        end
    end

    // Register writes
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_ff <= pof_pkg::CTRL_RST;
        end else if (ce_i && reg_wr_i &&
                     (reg_addr_i == pof_pkg::REG_CTRL)) begin
            ctrl_ff <= reg_wdata_i[pof_pkg::CTRL_W-1:0];
        end
    end

    // Register reads; data stand only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i && (reg_addr_i == pof_pkg::REG_CTRL)) begin
                reg_rdata_o[pof_pkg::CTRL_W-1:0] <= ctrl_ff;
            end else if (reg_rd_i && (reg_addr_i == pof_pkg::REG_STATUS)) begin
                reg_rdata_o[pof_pkg::CTRL_W-1:0]    <= cfg_ff;
                reg_rdata_o[pof_pkg::ST_FIELD]      <= field_active_flag_o;
                reg_rdata_o[pof_pkg::ST_ROW]        <= row_active_flag_o;
                reg_rdata_o[pof_pkg::ST_HAVE]       <= have_ff;
                reg_rdata_o[pof_pkg::ST_FULL]       <= f_full;
                reg_rdata_o[pof_pkg::ST_FRM_LO+:16] <= frm_ff;
            end
            // Unmapped addresses read as zero
        end
    end

    // Pixel register: loaded from the FIFO, freed after its last byte
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pix_ff  <= '0;
            have_ff <= 1'b0;
        end else if (pop) begin
            pix_ff  <= f_data;
            have_ff <= 1'b1;
        end else if ((emit0 && one_byte) || emit1) begin
            have_ff <= 1'b0;
        end
    end

    // Byte emitter, advances once per pixel clock period
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_ff               <= ST_IDLE;
            cfg_ff              <= pof_pkg::CTRL_RST;
            odd_ff              <= 1'b0;
            hold_ff             <= 8'h00;
            cidx_ff             <= 2'h0;
            eofp_ff             <= 1'b0;
            frm_ff              <= 16'h0000;
            field_active_flag_o <= 1'b0;
            row_active_flag_o   <= 1'b0;
            parallel_out_bus_o  <= 8'h00;
            aux_lsb_pins_o      <= 2'h0;
        end else if (tick) begin
            unique case (st_ff)
                ST_IDLE: begin
                    // One blank slot between lines
                    row_active_flag_o  <= 1'b0;
                    parallel_out_bus_o <= 8'h00;
                    aux_lsb_pins_o     <= 2'h0;
                    if (eofp_ff) begin
                        field_active_flag_o <= 1'b0;
                        eofp_ff             <= 1'b0;
                    end
                    if (have_ff) begin
                        cfg_ff  <= nxt_cfg;
                        odd_ff  <= 1'b0;
                        cidx_ff <= 2'h0;
                        if (pix_ff[pof_pkg::F_SOF]) begin
                            frm_ff <= frm_ff + 16'h0001;
                        end
                        if (nxt_cfg[2:0] == pof_pkg::MODE_BT656) begin
                            // Codes replace strobes in this mode
                            st_ff <= ST_CODE_S;
                        end else begin
                            st_ff <= ST_FIRST;
                            if (pix_ff[pof_pkg::F_SOF]) begin
                                field_active_flag_o <= 1'b1;
                            end
                        end
                    end
                end
                ST_CODE_S: begin
                    parallel_out_bus_o <= code_sel(cidx_ff, pof_pkg::SAV_XY);
                    cidx_ff            <= cidx_ff + 2'h1;
                    if (cidx_ff == 2'h3) begin
                        st_ff <= ST_FIRST;
                    end
                end
                ST_FIRST: begin
                    if (have_ff) begin
                        // Odd byte leaves on this falling edge
                        parallel_out_bus_o <= byte_sel(cfg_ff, pix_ff[23:0],
                                              odd_ff, hold_ff, 1'b0);
                        // Aux pins carry the low bits beside the top eight
                        aux_lsb_pins_o <= one_byte ? pix_ff[1:0]
                                                   : 2'h0;
                        // Bypass frames are flagged like pipeline ones
                        row_active_flag_o <= !is656 &&
                                             field_active_flag_o;
                        if (!odd_ff) begin
                            hold_ff <= cfg_ff[pof_pkg::CTRL_CSWAP] ?
                                       pix_ff[15:8] : pix_ff[7:0];
                        end
                        if (one_byte) begin
                            odd_ff <= !odd_ff;
                            if (pix_ff[pof_pkg::F_EOL]) begin
                                st_ff   <= ST_IDLE;
                                eofp_ff <= pix_ff[pof_pkg::F_EOF];
                            end
                        end else begin
                            st_ff <= ST_SECOND;
                        end
                    end else begin
                        // Starved: drop the row flag so nothing is captured
                        row_active_flag_o <= 1'b0;
                    end
                end
                ST_SECOND: begin
                    // Even byte one pixel clock after the odd one
                    parallel_out_bus_o <= byte_sel(cfg_ff, pix_ff[23:0],
                                          odd_ff, hold_ff, 1'b1);
                    aux_lsb_pins_o     <= 2'h0;
                    odd_ff             <= !odd_ff;
                    if (pix_ff[pof_pkg::F_EOL]) begin
                        // Lines leave in arrival order, never interleaved
                        st_ff   <= is656 ? ST_CODE_E : ST_IDLE;
                        eofp_ff <= pix_ff[pof_pkg::F_EOF];
                    end else begin
                        st_ff <= ST_FIRST;
                    end
                end
                ST_CODE_E: begin
                    parallel_out_bus_o <= code_sel(cidx_ff, pof_pkg::EAV_XY);
                    cidx_ff            <= cidx_ff + 2'h1;
                    if (cidx_ff == 2'h3) begin
                        st_ff <= ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Checks on the emitted byte stream
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_second_pending;
        (st_ff == ST_SECOND) && have_ff;
    endsequence

    property p_ycc_default;
        emit0 && (cfg_ff == {2'h0, pof_pkg::MODE_YCBCR}) && !odd_ff
        |=> parallel_out_bus_o == $past(pix_ff[15:8]);
    endproperty
    a_ycc_default: assert property (p_ycc_default)
        else $error("default YCbCr group does not start with Cb");

    property p_rgb16;
        emit0 && (cfg_ff[2:0] == pof_pkg::MODE_RGB16)
        |=> parallel_out_bus_o == {$past(pix_ff[23:19]), $past(pix_ff[15:13])};
    endproperty
    a_rgb16: assert property (p_rgb16)
        else $error("rgb16 odd byte wrong");

    property p_rgb15;
        emit1 && (cfg_ff[2:0] == pof_pkg::MODE_RGB15)
        |=> parallel_out_bus_o == {$past(pix_ff[13:11]), $past(pix_ff[7:3])};
    endproperty
    a_rgb15: assert property (p_rgb15)
        else $error("rgb15 even byte wrong");

    property p_rgb12h;
        emit0 && (cfg_ff[2:0] == pof_pkg::MODE_RGB12H)
        |=> parallel_out_bus_o == {4'h0, $past(pix_ff[23:20])};
    endproperty
    a_rgb12h: assert property (p_rgb12h)
        else $error("rgb12 high pad odd byte wrong");

    property p_raw_aux;
        emit0 && one_byte
        |=> {parallel_out_bus_o, aux_lsb_pins_o} == $past(pix_ff[9:0]);
    endproperty
    a_raw_aux: assert property (p_raw_aux)
        else $error("raw sample split over bus and aux pins wrong");

    property p_raw_2b;
        emit1 && (cfg_ff[2:0] == pof_pkg::MODE_RAW2B)
        |=> parallel_out_bus_o == {6'h00, $past(pix_ff[1:0])};
    endproperty
    a_raw_2b: assert property (p_raw_2b)
        else $error("raw second byte wrong");

    property p_no_strobe_656;
        (st_ff == ST_CODE_S) |-> !row_active_flag_o;
    endproperty
    a_no_strobe_656: assert property (p_no_strobe_656)
        else $error("row flag high in embedded code mode");

    property p_eav_xy;
        tick && (st_ff == ST_CODE_E) && (cidx_ff == 2'h3)
        |=> parallel_out_bus_o == pof_pkg::EAV_XY;
    endproperty
    a_eav_xy: assert property (p_eav_xy)
        else $error("end of line code byte wrong");

    property p_row_in_field;
        row_active_flag_o |-> field_active_flag_o;
    endproperty
    a_row_in_field: assert property (p_row_in_field)
        else $error("row flag outside field flag");

    property p_two_byte;
        emit0 && !one_byte |=> s_second_pending;
    endproperty
    a_two_byte: assert property (p_two_byte)
        else $error("even byte not pending after odd byte");

    property p_cfg_frame;
        !$stable(cfg_ff) |-> $past(ld_cfg);
    endproperty
    a_cfg_frame: assert property (p_cfg_frame)
        else $error("mode changed away from a frame start");
endmodule
`default_nettype wire

// ### logic/pof_pkg.sv
// Shared constants for the parallel output formatter
package pof_pkg;

    // Timing: core clock and pixel output clock periods
    localparam int CLK_PERIOD_NS  = 4;
    localparam int PCLK_PERIOD_NS = 64;
    // Core cycles per pixel clock half period, rounded down
    localparam int PCLK_HALF_CYC  = PCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // Input FIFO geometry
    localparam int FIFO_DEPTH = 16;
    localparam int PIX_W      = 24;
    localparam int WORD_W     = 27;
    // Marker bit positions inside a FIFO word
    localparam int F_SOF      = 26;
    localparam int F_EOL      = 25;
    localparam int F_EOF      = 24;

    // Output mode codes
    localparam logic [2:0] MODE_YCBCR  = 3'h0;
    localparam logic [2:0] MODE_BT656  = 3'h1;
    localparam logic [2:0] MODE_RGB16  = 3'h2;
    localparam logic [2:0] MODE_RGB15  = 3'h3;
    localparam logic [2:0] MODE_RGB12L = 3'h4;
    localparam logic [2:0] MODE_RGB12H = 3'h5;
    localparam logic [2:0] MODE_RAWAUX = 3'h6;
    localparam logic [2:0] MODE_RAW2B  = 3'h7;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;

    // Control register fields
    localparam int CTRL_W      = 5;
    localparam int CTRL_CSWAP  = 3;
    localparam int CTRL_YCSWAP = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // Status register fields
    localparam int ST_FIELD  = 5;
    localparam int ST_ROW    = 6;
    localparam int ST_HAVE   = 7;
    localparam int ST_FULL   = 8;
    localparam int ST_FRM_LO = 16;

    // Embedded timing reference bytes
    localparam logic [7:0] CODE_PRE0 = 8'hFF;
    localparam logic [7:0] CODE_PRE1 = 8'h00;
    localparam logic [7:0] SAV_XY    = 8'h80;
    localparam logic [7:0] EAV_XY    = 8'h9D;

endpackage

// ### testbench/parallel_output_formatter_test.sv
// Bench: frames in every output mode checked against a byte model
`timescale 1ns/1ps
`default_nettype none
module parallel_output_formatter_test;
    logic        clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic        ce_i = 1;  // Clock enable, dropped once per frame
    logic        pix_valid_i = 0, pix_sof_i = 0, pix_eol_i = 0, pix_eof_i = 0;
    logic [7:0]  reg_addr_i = 8'h00, bus;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [23:0] pix_data_i = 24'h0, px[2];
    logic        pix_ready_o, pclk, fval, lval;
    logic [1:0]  aux;
    // Swap variants first, last entry repeated for the final rewrite
    logic [4:0]  cfg[12] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h01, 5'h02,
                             5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h07};
    logic [9:0]  exp_q[$];  // Expected {aux, byte}
    int          n_errors = 0, samples_checked = 0, cyc = 0;
    pof_formatter #(.PCLK_HALF(8), .FIFO_DEPTH(16)) DUT (.clk_i, .rst_b_i,
        .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .pix_valid_i, .pix_ready_o, .pix_sof_i, .pix_eol_i,
        .pix_eof_i, .pix_data_i, .pixel_output_clock_o(pclk),
        .field_active_flag_o(fval), .row_active_flag_o(lval),
        .parallel_out_bus_o(bus), .aux_lsb_pins_o(aux));
    pof_rx_model rx (.clk_i, .pclk_i(pclk), .fval_i(fval), .lval_i(lval),
        .bus_i(bus), .aux_i(aux));
    // 4 ns core clock
    initial forever #2 clk_i = ~clk_i;
    // Hang guard, well above the ~7000 cycles the run needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        check(reg_rdata_o, e);
        @(posedge clk_i);
    endtask
    task automatic put(input logic [7:0] b, input logic [1:0] a);
        exp_q.push_back({a, b});
    endtask
    // One two-pixel line, then the bytes it must produce
    task automatic line(input logic [4:0] c, input logic sof, eof);
        logic [7:0] r, g, b;
        for (int i = 0; i < 2; i++) begin
            // Raw modes carry a ten-bit sample only
            px[i] = (c[2:1] == 2'h3) ? {14'h0, 10'($urandom)} : 24'($urandom);
            pix_data_i <= px[i];
            pix_valid_i <= 1'b1;
            pix_sof_i <= sof && i == 0;
            pix_eol_i <= i == 1;
            pix_eof_i <= eof && i == 1;
            do @(posedge clk_i); while (pix_ready_o !== 1'b1);
        end
        pix_valid_i <= 1'b0;
        r = c[3] ? px[0][7:0] : px[0][15:8];  // Chroma of even pixel
        g = c[3] ? px[0][15:8] : px[0][7:0];
        if (c[2:0] == 3'h0 && c[4]) begin
            put(px[0][23:16], 2'h0);
            put(r, 2'h0);
            put(px[1][23:16], 2'h0);
            put(g, 2'h0);
        end else if (c[2:0] == 3'h0) begin
            put(r, 2'h0);
            put(px[0][23:16], 2'h0);
            put(g, 2'h0);
            put(px[1][23:16], 2'h0);
        end
        for (int i = 0; i < 2; i++) begin
            {r, g, b} = px[i];
            case (c[2:0])
                3'h2: begin
                    put({r[7:3], g[7:5]}, 2'h0);
                    put({g[4:2], b[7:3]}, 2'h0);
                end
                3'h3: begin
                    put({1'b0, r[7:3], g[7:6]}, 2'h0);
                    put({g[5:3], b[7:3]}, 2'h0);
                end
                3'h4: begin
                    put({r[7:4], g[7:4]}, 2'h0);
                    put({b[7:4], 4'h0}, 2'h0);
                end
                3'h5: begin
                    put({4'h0, r[7:4]}, 2'h0);
                    put({g[7:4], b[7:4]}, 2'h0);
                end
                3'h6: put(px[i][9:2], px[i][1:0]);
                3'h7: begin
                    put(px[i][9:2], 2'h0);
                    put({6'h0, px[i][1:0]}, 2'h0);
                end
                default: ;  // YCbCr bytes queued above; embedded codes only, flags stay low
            endcase
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h9D88EE1C));
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        // Nonzero pattern so a lost write shows; upper bits read zero
        wr(pof_pkg::REG_CTRL, {27'h5A5A5A5, 5'h1F});
        rd(pof_pkg::REG_CTRL, 32'h0000_001F);
        rd(8'h08, 32'h0);
        wr(pof_pkg::REG_CTRL, {27'h0, cfg[0]});
        for (int k = 0; k < 11; k++) begin
            line(cfg[k], 1'b1, 1'b0);
            // New selection mid-frame must wait for the next frame
            repeat (40) @(posedge clk_i);
            wr(pof_pkg::REG_CTRL, {27'h0, cfg[k+1]});
            line(cfg[k], 1'b0, 1'b1);
            // Freeze mid-frame; the stream must resume intact
            ce_i <= 1'b0;
            repeat ($urandom_range(8, 1)) @(posedge clk_i);
            ce_i <= 1'b1;
            for (int w = 0; w < 2000 && rx.got.size() < exp_q.size(); w++)
                @(posedge clk_i);
            // Two embedded-code lines take ~420 cycles, nothing captured
            repeat (480) @(posedge clk_i);
            check(32'(rx.got.size()), 32'(exp_q.size()));
            while (exp_q.size() > 0 && rx.got.size() > 0)
                check(32'(rx.got.pop_front()),
                      32'(exp_q.pop_front()));
        end
        // Eleven frames started, last mode raw two-byte, all idle
        rd(pof_pkg::REG_STATUS, {16'h000B, 16'h0007});
        end_of_test();
    end
endmodule
`default_nettype wire

// ### testbench/pof_rx_model.sv
// Capture side model: latches port bytes while both flags are high
`timescale 1ns/1ps
`default_nettype none
module pof_rx_model (
    // Core clock used to find pixel clock edges
    input  wire logic       clk_i,
    // Parallel port from the formatter
    input  wire logic       pclk_i,
    input  wire logic       fval_i,
    input  wire logic       lval_i,
    input  wire logic [7:0] bus_i,
    input  wire logic [1:0] aux_i
);
    logic       pclk_ff;  // Last pixel clock sample
    logic [9:0] got[$];   // Captured {aux, byte}
    // Capture on pixel clock rise, only inside an active line
    always @(posedge clk_i) begin
        pclk_ff <= pclk_i;
        if (pclk_i && !pclk_ff && fval_i && lval_i) begin
            got.push_back({aux_i, bus_i});
        end
    end
endmodule
`default_nettype wire
